// ---- core/sps_addr_dec.sv ----
// register address decoder for stack bytes and paged range
`timescale 1ns/1ps
`default_nettype none
module sps_addr_dec
(
   sps_dec_if.dec dif
);
   import sps_pkg::*;

   logic paged;

   // stack bytes decode on every page
   assign dif.hit_active = (dif.addr == ADDR_ACTIVE_PAGE);
   assign dif.hit_second = (dif.addr == ADDR_SECOND_ENTRY);
   assign dif.hit_third = (dif.addr == ADDR_THIRD_ENTRY); // [R07]
   assign paged = sps_in_paged(dif.addr);
   assign dif.sel_p0 = paged && (dif.page == PAGE_ZERO); // [R08]
   assign dif.sel_p2 = paged && (dif.page == PAGE_TWO); // [R08]
   assign dif.sel_pf = paged && (dif.page == PAGE_FIFTEEN); // [R08]
endmodule : sps_addr_dec
`default_nettype wire

// ---- core/sps_dec_if.sv ----
// address decode signals between stack control and decoder
`timescale 1ns/1ps
`default_nettype none
interface sps_dec_if;
   logic [7:0] addr;
   logic [7:0] page;
   logic hit_active;
   logic hit_second;
   logic hit_third;
   logic sel_p0;
   logic sel_p2;
   logic sel_pf;
   modport ctl (output addr, output page, input hit_active,
      input hit_second, input hit_third, input sel_p0, input sel_p2,
      input sel_pf);
   modport dec (input addr, input page, output hit_active,
      output hit_second, output hit_third, output sel_p0, output sel_p2,
      output sel_pf);
endinterface : sps_dec_if
`default_nettype wire

// ---- core/sps_page_stack.sv ----
// three-entry page context stack with register access and page decode
// Function
// [R01] three byte entries: active page, second entry, third entry
// [R02] interrupt return copies third entry into second entry
// [R03] software write to third entry replaces deepest stack value
// [R04] reading third entry returns deepest value without side effect
// [R05] register reads and writes never push or pop the stack
// [R06] only interrupt entry pushes and interrupt return pops
// [R07] third entry register sits at 0x86 on every page
// [R08] addresses 0xC0 to 0xFF decode with active page 0x0, 0x2, 0xF
// [R09] interrupt return loads second entry into active page
// [R10] with auto paging, entry loads interrupting peripheral page
// [R11] entry shifts page down one level; all entries reset to zero
`timescale 1ns/1ps
`default_nettype none
module sps_page_stack
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire sps_pkg::sps_byte_t WDATA,
   input wire logic INT_ENTRY,
   input wire logic INT_RETURN,
   input wire logic AUTO_PAGE_EN,
   input wire sps_pkg::sps_byte_t INT_PAGE,
   output logic [7:0] RDATA,
   output logic RD_HIT,
   output logic [7:0] ACTIVE_PAGE,
   output logic [7:0] SECOND_ENTRY,
   output logic [7:0] THIRD_ENTRY,
   output logic SEL_PAGE0,
   output logic SEL_PAGE2,
   output logic SEL_PAGEF
);
   import sps_pkg::*;

   // one-hot code of the stack operation taken this cycle
   typedef enum logic [3:0]
   {
      OP_IDLE = 4'h1,
      OP_POP = 4'h2,
      OP_PUSH = 4'h4,
      OP_WRITE = 4'h8
   } sps_op_t;

   // a return beats an entry, and either beats a software write
   function automatic sps_op_t sps_pick_op
   (
      input logic ret,
      input logic ent,
      input logic wr
   );
      sps_op_t op;
      op = OP_IDLE;
      if (ret)
      begin
         op = OP_POP;
      end
      else if (ent)
      begin
         op = OP_PUSH;
      end
      else if (wr)
      begin
         op = OP_WRITE;
      end
      return op;
   endfunction : sps_pick_op

   // read data of the addressed stack byte; idle value when none is hit
   function automatic sps_byte_t sps_read_byte
   (
      input sps_state_t st,
      input logic hit_a,
      input logic hit_s,
      input logic hit_t
   );
      sps_byte_t val;
      val = RDATA_IDLE;
      if (hit_a)
      begin
         val = st.active_page_selector;
      end
      else if (hit_s)
      begin
         val = st.page_stack_second_entry;
      end
      else if (hit_t)
      begin
         val = st.page_stack_third_entry; // [R04]
      end
      return val;
   endfunction : sps_read_byte

   // a software write lands on its own byte and never shifts the stack
   function automatic sps_state_t sps_write_byte
   (
      input sps_state_t st,
      input logic hit_a,
      input logic hit_s,
      input logic hit_t,
      input sps_byte_t wdata
   );
      sps_state_t upd;
      upd = st;
      if (hit_a)
      begin
         upd.active_page_selector = wdata; // [R05]
      end
      else if (hit_s)
      begin
         upd.page_stack_second_entry = wdata; // [R05]
      end
      else if (hit_t)
      begin
         upd.page_stack_third_entry = wdata; // [R03]
      end
      return upd;
   endfunction : sps_write_byte

   // operation that wins this cycle
   sps_op_t op_sel;
   assign op_sel = sps_pick_op(INT_RETURN, INT_ENTRY, WR_EN); // [R06]

   sps_state_t state_reg;
   sps_state_t state_next;
   sps_dec_if dif ();

   assign dif.addr = ADDR;
   assign dif.page = state_reg.active_page_selector;

   sps_addr_dec u_dec
   (
      .dif(dif.dec)
   );

   always_comb
   begin
      state_next = state_reg;
      state_next.rd_hit = 1'b0;
      state_next.rdata = RDATA_IDLE;
      // paged select follows the page in force for this access
      state_next.sel_p0 = dif.sel_p0; // [R08]
      state_next.sel_p2 = dif.sel_p2; // [R08]
      state_next.sel_pf = dif.sel_pf; // [R08]
      // reads only look; they never move the stack
      if (RD_EN)
      begin
         state_next.rdata = sps_read_byte(state_reg, dif.hit_active,
            dif.hit_second, dif.hit_third); // [R04]
         state_next.rd_hit = dif.hit_active || dif.hit_second ||
            dif.hit_third;
      end
      // events beat software writes; a write in a push or pop is dropped
      case (op_sel)
         OP_POP:
         begin
            state_next.active_page_selector =
               state_reg.page_stack_second_entry; // [R09] [R06]
            state_next.page_stack_second_entry =
               state_reg.page_stack_third_entry; // [R02]
         end
         OP_PUSH:
         begin
            // the old third entry drops off the bottom
            state_next.page_stack_third_entry =
               state_reg.page_stack_second_entry; // [R11] [R06]
            state_next.page_stack_second_entry =
               state_reg.active_page_selector; // [R11] [R01]
            if (AUTO_PAGE_EN)
            begin
               state_next.active_page_selector = INT_PAGE; // [R10]
            end
         end
         OP_WRITE:
         begin
            // each write touches its own byte only, no shift
            state_next = sps_write_byte(state_next, dif.hit_active,
               dif.hit_second, dif.hit_third, WDATA); // [R05] [R03]
         end
         OP_IDLE:
         begin
            // nothing moves
         end
         default:
         begin
            // stack holds
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         state_reg.active_page_selector <= ENTRY_RESET; // [R11]
         state_reg.page_stack_second_entry <= ENTRY_RESET; // [R11]
         state_reg.page_stack_third_entry <= ENTRY_RESET; // [R11]
         state_reg.rdata <= RDATA_IDLE;
         state_reg.rd_hit <= 1'b0;
         state_reg.sel_p0 <= 1'b0;
         state_reg.sel_p2 <= 1'b0;
         state_reg.sel_pf <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign RDATA = state_reg.rdata;
   assign RD_HIT = state_reg.rd_hit;
   assign ACTIVE_PAGE = state_reg.active_page_selector;
   assign SECOND_ENTRY = state_reg.page_stack_second_entry;
   assign THIRD_ENTRY = state_reg.page_stack_third_entry;
   assign SEL_PAGE0 = state_reg.sel_p0;
   assign SEL_PAGE2 = state_reg.sel_p2;
   assign SEL_PAGEF = state_reg.sel_pf;
endmodule : sps_page_stack
`default_nettype wire

// ---- core/sps_pkg.sv ----
// constants and state type for the page context stack
package sps_pkg;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'ha7;
   localparam logic [7:0] ADDR_SECOND_ENTRY = 8'h85;
   localparam logic [7:0] ADDR_THIRD_ENTRY = 8'h86;
   localparam logic [7:0] ADDR_PAGED_LO = 8'hc0;
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] PAGE_TWO = 8'h02;
   localparam logic [7:0] PAGE_FIFTEEN = 8'h0f;
   localparam logic [7:0] ENTRY_RESET = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   typedef logic [DATA_W-1:0] sps_byte_t;

   typedef struct packed {
      sps_byte_t active_page_selector;
      sps_byte_t page_stack_second_entry;
      sps_byte_t page_stack_third_entry;
      sps_byte_t rdata;
      logic rd_hit;
      logic sel_p0;
      logic sel_p2;
      logic sel_pf;
   } sps_state_t;

   function automatic logic sps_in_paged(input logic [7:0] addr);
      sps_in_paged = (addr >= ADDR_PAGED_LO);
   endfunction : sps_in_paged
endpackage : sps_pkg

// ---- test/sps_core_model.sv ----
// core side model issuing interrupt entry and return pulses
`timescale 1ns/1ps
`default_nettype none
module sps_core_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ent_req,
   input wire logic ret_req,
   output logic int_entry,
   output logic int_return
);
   logic [3:0] depth_reg;
   // a return with nothing nested is never issued by a real core
   assign int_return = ret_req && depth_reg != 4'h0;
   assign int_entry = ent_req && !int_return;
   always_ff @(posedge clk)
      if (!rst_n) depth_reg <= 4'h0;
      else depth_reg <= depth_reg + int_entry - int_return;
endmodule : sps_core_model
`default_nettype wire

// ---- test/sps_page_stack_monitor.sv ----
// port assertions for the page context stack
`timescale 1ns/1ps
`default_nettype none
module sps_mon
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire sps_pkg::sps_byte_t WDATA,
   input wire logic INT_ENTRY,
   input wire logic INT_RETURN,
   input wire logic AUTO_PAGE_EN,
   input wire sps_pkg::sps_byte_t INT_PAGE,
   input wire logic [7:0] RDATA,
   input wire logic RD_HIT,
   input wire logic [7:0] ACTIVE_PAGE,
   input wire logic [7:0] SECOND_ENTRY,
   input wire logic [7:0] THIRD_ENTRY,
   input wire logic SEL_PAGE0,
   input wire logic SEL_PAGE2,
   input wire logic SEL_PAGEF
);
   import sps_pkg::*;
   wire logic quiet = !INT_ENTRY && !INT_RETURN;
   wire logic push = INT_ENTRY && !INT_RETURN;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   pop_shift_a: assert property (INT_RETURN |=>
      ACTIVE_PAGE == $past(SECOND_ENTRY) &&
      SECOND_ENTRY == $past(THIRD_ENTRY)) else $error("pop wrong");
   push_shift_a: assert property (push |=>
      SECOND_ENTRY == $past(ACTIVE_PAGE) &&
      THIRD_ENTRY == $past(SECOND_ENTRY)) else $error("push wrong");
   auto_page_a: assert property (push |=> ACTIVE_PAGE ==
      ($past(AUTO_PAGE_EN) ? $past(INT_PAGE) : $past(ACTIVE_PAGE)))
      else $error("entry page wrong");
   third_write_a: assert property (quiet && WR_EN &&
      ADDR == ADDR_THIRD_ENTRY |=> THIRD_ENTRY == $past(WDATA) &&
      $stable(SECOND_ENTRY)) else $error("third write wrong");
   second_write_a: assert property (quiet && WR_EN &&
      ADDR == ADDR_SECOND_ENTRY |=> SECOND_ENTRY == $past(WDATA) &&
      $stable(THIRD_ENTRY)) else $error("second write wrong");
   third_read_a: assert property (RD_EN &&
      ADDR == ADDR_THIRD_ENTRY |=> RD_HIT && RDATA == $past(THIRD_ENTRY))
      else $error("third read wrong");
   no_shift_a: assert property (quiet && !WR_EN |=>
      $stable({ACTIVE_PAGE, SECOND_ENTRY, THIRD_ENTRY}))
      else $error("stack moved");
   page_sel_a: assert property (1'b1 |=>
      {SEL_PAGE0, SEL_PAGE2, SEL_PAGEF} == ({3{$past(ADDR) >= 8'hc0}} &
      {$past(ACTIVE_PAGE) == 8'h00, $past(ACTIVE_PAGE) == 8'h02,
      $past(ACTIVE_PAGE) == 8'h0f})) else $error("page select wrong");
endmodule : sps_mon
bind sps_page_stack sps_mon mon (.CLK, .RST_N, .ADDR, .WR_EN, .RD_EN,
   .WDATA, .INT_ENTRY, .INT_RETURN, .AUTO_PAGE_EN, .INT_PAGE, .RDATA,
   .RD_HIT, .ACTIVE_PAGE, .SECOND_ENTRY, .THIRD_ENTRY, .SEL_PAGE0,
   .SEL_PAGE2, .SEL_PAGEF);
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the page context stack
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sps_pkg::*;
   logic CLK = 0, RST_N = 0, WR_EN = 0, RD_EN = 0, AUTO_PAGE_EN = 0;
   logic ent = 0, ret = 0, INT_ENTRY, INT_RETURN, RD_HIT;
   logic SEL_PAGE0, SEL_PAGE2, SEL_PAGEF;
   logic [7:0] ADDR = 0, RDATA, ACTIVE_PAGE, SECOND_ENTRY, THIRD_ENTRY;
   sps_byte_t WDATA = 0, INT_PAGE = 0;
   logic [7:0] ap = 0, se = 0, te = 0;
   int fails = 0, compares = 0, d = 0, cyc = 0;
   sps_page_stack dut (.CLK, .RST_N, .ADDR, .WR_EN, .RD_EN, .WDATA,
      .INT_ENTRY, .INT_RETURN, .AUTO_PAGE_EN, .INT_PAGE, .RDATA, .RD_HIT,
      .ACTIVE_PAGE, .SECOND_ENTRY, .THIRD_ENTRY, .SEL_PAGE0, .SEL_PAGE2,
      .SEL_PAGEF);
   sps_core_model core (.clk(CLK), .rst_n(RST_N), .ent_req(ent),
      .ret_req(ret), .int_entry(INT_ENTRY), .int_return(INT_RETURN));
   always #10 CLK = ~CLK;
   function automatic logic [8:0] rd_exp(input logic r, input logic [7:0] a);
      rd_exp = !r ? 9'h000 : a == 8'ha7 ? {1'b1, ap} : a == 8'h85 ?
         {1'b1, se} : a == 8'h86 ? {1'b1, te} : 9'h000;
   endfunction : rd_exp
   task automatic chk(input string n, input logic [23:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // caller must sit at a falling edge; return only while nested
   task automatic step(input logic w, r, e, t, au, input logic [7:0] a, v);
      logic [8:0] rx;
      logic [2:0] sel;
      {WR_EN, RD_EN, ent, ret, AUTO_PAGE_EN} = {w, r, e, t, au};
      {ADDR, WDATA, INT_PAGE} = {a, v, v};
      rx = rd_exp(r, a);
      sel = {3{a >= 8'hc0}} & {ap == 8'h00, ap == 8'h02, ap == 8'h0f};
      if (t) {ap, se} = {se, te};
      else if (e) {ap, se, te} = {au ? v : ap, ap, se};
      else if (w && a == 8'ha7) ap = v;
      else if (w && a == 8'h85) se = v;
      else if (w && a == 8'h86) te = v;
      d = d + e - t;
      @(negedge CLK);
      chk("active", ACTIVE_PAGE, ap);
      chk("second", SECOND_ENTRY, se);
      chk("third", THIRD_ENTRY, te);
      chk("read", {RD_HIT, RDATA}, rx);
      chk("select", {SEL_PAGE0, SEL_PAGE2, SEL_PAGEF}, sel);
   endtask : step
   always @(posedge CLK)
      if (++cyc > 2000)
      begin
         fails++;
         end_of_test();
      end
   initial
   begin
      logic [7:0] a, v;
      logic t, e;
      void'($urandom(71));
      repeat (2) @(negedge CLK);
      RST_N = 1;
      step(0, 1, 0, 0, 0, 8'ha7, 0);
      step(0, 1, 0, 0, 0, 8'h85, 0);
      step(0, 1, 0, 0, 0, 8'h86, 0);
      $display("test reset done");
      step(1, 1, 0, 0, 0, 8'h86, 8'h5a);
      step(0, 0, 1, 0, 1, 8'hc5, 8'h02);
      step(0, 0, 1, 0, 1, 8'hc5, 8'h0f);
      step(0, 1, 1, 0, 0, 8'hff, 8'h33);
      step(1, 1, 0, 1, 0, 8'h86, 8'h33);
      step(1, 1, 0, 0, 0, 8'h87, 8'h44);
      step(1, 1, 0, 0, 0, 8'ha7, 8'h0f);
      step(0, 0, 0, 1, 0, 8'hc0, 0);
      step(0, 0, 0, 1, 0, 8'hc0, 0);
      $display("test corners done");
      repeat (300)
      begin
         a = $urandom_range(3) == 0 ? 8'($urandom) :
            8'(8'h85 + $urandom_range(1));
         v = 8'($urandom) & ($urandom_range(1) ? 8'h0f : 8'hff);
         t = d > 0 && $urandom_range(3) == 0;
         e = !t && d < 15 && $urandom_range(3) == 0;
         step(1'($urandom), 1'($urandom), e, t, 1'($urandom), a, v);
      end
      $display("test random done");
      RST_N = 0;
      {ap, se, te} = 24'h000000;
      d = 0;
      repeat (2) @(negedge CLK);
      chk("reset active", ACTIVE_PAGE, 8'h00);
      chk("reset second", SECOND_ENTRY, 8'h00);
      chk("reset third", THIRD_ENTRY, 8'h00);
      RST_N = 1;
      step(0, 1, 1, 0, 1, 8'h86, 8'h02);
      step(0, 0, 0, 1, 0, 8'hc1, 8'h00);
      $display("test reset again done");
      step(0, 0, 0, 0, 0, 8'h00, 0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
